// file: test/ccsb_state_bits_checker.sv
// port assertions for the controller state bits block
// assumes bound onto ccsb_state_bits
`timescale 1ns/1ps
module ccsb_state_bits_checker #(
  parameter int unsigned STOP_W = 4
) (
  input wire logic              clk_in,
  input wire logic              resetn_in,
  input wire logic              init_in,
  input wire logic              chan_start_in,
  input wire logic              chan_done_in,
  input wire logic [STOP_W-1:0] stop_cond_in,
  input wire logic              host_wr_in,
  input wire logic [2:0]        host_wr_reg_in,
  input wire logic              host_wr_ok_out,
  input wire logic              host_write_lock_out,
  input wire logic              first_time_state_out,
  input wire logic              ts_tick_out,
  input wire logic              transfer_stop_any_out,
  input wire logic              skip_fetch_out,
  input wire logic              skip_command_out,
  input wire logic              skip_chan_seq_out,
  input wire logic [15:0]       controller_state_bits_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire [15:0] cb = controller_state_bits_out;
  wire [2:0]  ph = cb[14:12];
  // =========================================
  // properties
  property p_wr;
    host_wr_ok_out == (host_wr_in && !(cb[15] && host_wr_reg_in < 3'h5));
  endproperty
  a_wr: assert property (p_wr) else $error("write gate");
  property p_start; chan_start_in && !init_in |=> host_write_lock_out;
  endproperty
  a_start: assert property (p_start) else $error("lock set");
  property p_done; chan_done_in && !chan_start_in |=> !cb[15]; endproperty
  a_done: assert property (p_done) else $error("lock clear");
  property p_ts; ts_tick_out && !init_in |=> cb[11] != $past(cb[11]);
  endproperty
  a_ts: assert property (p_ts) else $error("time state");
  property p_stop; transfer_stop_any_out == (|stop_cond_in &&
    (ph == 3'h5 || ph == 3'h6)) && cb[7] == transfer_stop_any_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_fetch; skip_fetch_out == (cb[6] && ph == 3'h0); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch");
  property p_cmd; skip_command_out == (cb[6] && ph == 3'h3); endproperty
  a_cmd: assert property (p_cmd) else $error("command");
  property p_chan; skip_chan_seq_out == (cb[6] && !cb[9] && !cb[11]);
  endproperty
  a_chan: assert property (p_chan) else $error("chan skip");
  property p_init; init_in |=> (cb & 16'hffc0) == 16'h0800; endproperty
  a_init: assert property (p_init) else $error("init");
  property p_low; init_in |-> (cb[5:0] & 6'h3b) == 6'h00; endproperty
  a_low: assert property (p_low) else $error("low mask");
endmodule : ccsb_state_bits_checker

// file: test/ccsb_state_bits_tb_top.sv
// bench for the controller state bits block
// assumes the stop source model and the bound checker
`timescale 1ns/1ps
module ccsb_state_bits_tb_top;
  logic clk_in = 0, resetn_in = 0, init_in = 0, host_wr_in = 0, lk_e, wok;
  logic chan_start_in = 0, chan_done_in = 0, ok, lk, ft, tk, sf, sc, sk;
  logic [15:0] ev = 0, cb;
  logic [5:0]  low = 0;
  logic [2:0]  wreg = 0, w;
  logic [3:0]  stop;
  logic [31:0] m;
  logic [63:0] q[$];
  logic [63:0] note;
  wire  [31:0] obs = {11'h0, lk, ok, sk, sc, sf, cb};
  int n_fail = 0, n_compared = 0, cyc = 0, i;
  ccsb_stop_src ccsb_stop_src_i (.clk_in(clk_in), .stop_out(stop));
  ccsb_state_bits ccsb_state_bits_i (.clk_in(clk_in),
    .resetn_in(resetn_in), .init_in(init_in), .chan_start_in(chan_start_in),
    .chan_done_in(chan_done_in), .phase_load_in(ev[15]),
    .phase_in(ev[14:12]), .quick_busy_set_in(ev[11]),
    .quick_busy_clr_in(ev[10]), .sync_set_in(ev[9]), .sync_clr_in(ev[8]),
    .udv_set_in(ev[7]), .udv_clr_in(ev[6]), .stop_cond_in(stop),
    .first_byte_in(ev[5]), .zero_pointer_in(ev[4]), .no_addr_out_in(ev[3]),
    .parity_good_in(ev[2]), .status_pending_in(ev[1]), .skip_clr_in(ev[0]),
    .low_bits_in(low), .host_wr_in(host_wr_in), .host_wr_reg_in(wreg),
    .host_wr_ok_out(ok), .host_write_lock_out(lk),
    .first_time_state_out(ft), .ts_tick_out(tk),
    .transfer_stop_any_out(), .skip_fetch_out(sf), .skip_command_out(sc),
    .skip_chan_seq_out(sk), .controller_state_bits_out(cb));
  initial forever #2.5 clk_in = ~clk_in;
  task cmp(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // events are held until the edge that carries a time-state tick
  task pulse(input logic [15:0] v);
    @(posedge clk_in) ev <= v;
    do @(posedge clk_in); while (!tk);
    ev <= 16'h0000;
  endtask : pulse
  // as pulse, but the tick must fall in the given time state
  task pulse_ts(input logic [15:0] v, input logic f);
    @(posedge clk_in) ev <= v;
    do @(posedge clk_in); while (!(tk && ft == f));
    ev <= 16'h0000;
  endtask : pulse_ts
  // the watcher takes the note at the next falling edge
  task expect_bits(input logic [31:0] mk, v);
    q.push_back({mk, v});
    @(negedge clk_in);
  endtask : expect_bits
  always @(negedge clk_in) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      wrap_up();
    end else if (q.size() > 0) begin
      note = q.pop_front();
      cmp("state", obs & note[63:32], note[31:0]);
    end
  end
  initial begin
    void'($urandom(32'h80db));
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    expect_bits(32'h0000_ffc0, 32'h0000_0800);
    $display("reset test end");
    for (i = 0; i < 8; i++) begin
      pulse({1'b1, i[2:0], 12'h000});
      expect_bits(32'h0000_7000, {17'h0, i[2:0], 12'h000});
    end
    $display("phase test end");
    for (i = 0; i < 3; i++) begin
      m = {16'h0, 16'h0400 >> i};
      pulse(16'h0800 >> 2*i);
      expect_bits(m, m);
      pulse(16'h0c00 >> 2*i);
      expect_bits(m, m);
      pulse(16'h0400 >> 2*i);
      expect_bits(m, 32'h0000_0000);
    end
    $display("flag test end");
    for (i = 5; i > 3; i--) begin
      pulse(16'h0001);
      expect_bits(32'h0000_0040, 32'h0000_0000);
      pulse(16'h0001 << i);
      expect_bits(32'h0000_0040, 32'h0000_0040);
    end
    pulse(16'h8001);
    pulse(16'h0008);
    expect_bits(32'h0001_7040, 32'h0001_0040);
    pulse(16'ha000);
    pulse(16'h0004);
    expect_bits(32'h0003_7040, 32'h0000_2040);
    pulse(16'h0000);
    expect_bits(32'h0000_0040, 32'h0000_0000);
    pulse(16'hb004);
    expect_bits(32'h0003_7040, 32'h0002_3040);
    $display("skip test end");
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in) w = 3'($urandom);
      wreg <= w;
      host_wr_in <= 1'b1;
      chan_start_in <= (i == 0);
      chan_done_in <= (i == 8);
      low <= 6'($urandom);
      lk_e = i > 0 && i < 9;
      wok = !(lk_e && w < 3'h5);
      expect_bits(32'h0018_8000,
                  {11'h0, lk_e, wok, 3'h0, lk_e, 15'h0});
    end
    $display("lock test end");
    @(posedge clk_in) init_in <= 1'b1;
    expect_bits(32'h0000_003f, {26'h0, low & 6'h04});
    @(posedge clk_in) init_in <= 1'b0;
    expect_bits(32'h0000_ffc0, 32'h0000_0800);
    $display("init test end");
    @(posedge clk_in) chan_start_in <= 1'b1;
    @(posedge clk_in) chan_start_in <= 1'b0;
    pulse_ts(16'h0002, 1'b1);
    expect_bits(32'h0001_8840, 32'h0001_8040);
    pulse_ts(16'h0000, 1'b1);
    expect_bits(32'h0000_0040, 32'h0000_0000);
    pulse(16'h9000);
    pulse_ts(16'h0a00, 1'b1);
    expect_bits(32'h0004_0e40, 32'h0004_0440);
    $display("channel test end");
    @(posedge clk_in);
    wrap_up();
  end
endmodule : ccsb_state_bits_tb_top
bind ccsb_state_bits ccsb_state_bits_checker #(
  .STOP_W (STOP_W)
) chk_i (
  .clk_in                    (clk_in),
  .resetn_in                 (resetn_in),
  .init_in                   (init_in),
  .chan_start_in             (chan_start_in),
  .chan_done_in              (chan_done_in),
  .stop_cond_in              (stop_cond_in),
  .host_wr_in                (host_wr_in),
  .host_wr_reg_in            (host_wr_reg_in),
  .host_wr_ok_out            (host_wr_ok_out),
  .host_write_lock_out       (host_write_lock_out),
  .first_time_state_out      (first_time_state_out),
  .ts_tick_out               (ts_tick_out),
  .transfer_stop_any_out     (transfer_stop_any_out),
  .skip_fetch_out            (skip_fetch_out),
  .skip_command_out          (skip_command_out),
  .skip_chan_seq_out         (skip_chan_seq_out),
  .controller_state_bits_out (controller_state_bits_out)
);

// file: test/ccsb_stop_src.sv
// far-side stop condition source: random levels every cycle
// assumes the bench seeds the generator
`timescale 1ns/1ps
module ccsb_stop_src (
  input  wire logic       clk_in,
  output logic      [3:0] stop_out
);
  always @(posedge clk_in) stop_out <= 4'($urandom);
endmodule : ccsb_stop_src

// file: verilog/ccsb_pkg.sv
// constants of the controller state bits block
// assumes a single 200 MHz clock; no bus beyond the documented read port
package ccsb_pkg;
  localparam int unsigned CCSB_LOCK_BIT     = 15;
  localparam int unsigned CCSB_PHASE_HI     = 14;
  localparam int unsigned CCSB_PHASE_LO     = 12;
  localparam int unsigned CCSB_TS_BIT       = 11;
  localparam int unsigned CCSB_QUICK_BIT    = 10;
  localparam int unsigned CCSB_SYNC_BIT     = 9;
  localparam int unsigned CCSB_UDV_BIT      = 8;
  localparam int unsigned CCSB_STOP_BIT     = 7;
  localparam int unsigned CCSB_SKIP_BIT     = 6;
  localparam int unsigned CCSB_LOW_W        = 6;
  localparam int unsigned CCSB_ONLINE_BIT   = 2;
  localparam int unsigned CCSB_LOCKED_REGS  = 5;
  localparam int unsigned CCSB_TS_DIV       = 4;
  localparam logic [2:0]  CCSB_PHASE_RESET  = 3'h0;
  localparam logic [2:0]  CCSB_PHASE_0      = 3'h0;
  localparam logic [2:0]  CCSB_PHASE_2      = 3'h2;
  localparam logic [2:0]  CCSB_PHASE_3      = 3'h3;
  localparam logic [2:0]  CCSB_PHASE_5      = 3'h5;
  localparam logic [2:0]  CCSB_PHASE_6      = 3'h6;
  typedef enum logic [1:0] {
    CCSB_SEQ_IDLE = 2'b01,
    CCSB_SEQ_CHAN = 2'b10
  } ccsb_seq_t;
endpackage : ccsb_pkg

// file: verilog/ccsb_state_bits.sv
// controller state bits: sequencer flags and their read-only view
// assumes sequencer events are synchronous and held until a time-state tick
`timescale 1ns/1ps
module ccsb_state_bits
  import ccsb_pkg::*;
#(
  parameter int unsigned STOP_W = 4,
  parameter int unsigned TS_DIV = CCSB_TS_DIV
) (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 init_in,
  input  wire logic                 chan_start_in,
  input  wire logic                 chan_done_in,
  input  wire logic                 phase_load_in,
  input  wire logic [2:0]           phase_in,
  input  wire logic                 quick_busy_set_in,
  input  wire logic                 quick_busy_clr_in,
  input  wire logic                 sync_set_in,
  input  wire logic                 sync_clr_in,
  input  wire logic                 udv_set_in,
  input  wire logic                 udv_clr_in,
  input  wire logic [STOP_W-1:0]    stop_cond_in,
  input  wire logic                 first_byte_in,
  input  wire logic                 zero_pointer_in,
  input  wire logic                 no_addr_out_in,
  input  wire logic                 parity_good_in,
  input  wire logic                 status_pending_in,
  input  wire logic                 skip_clr_in,
  input  wire logic [CCSB_LOW_W-1:0] low_bits_in,
  input  wire logic                 host_wr_in,
  input  wire logic [2:0]           host_wr_reg_in,
  output logic                      host_wr_ok_out,
  output logic                      host_write_lock_out,
  output logic                      first_time_state_out,
  output logic                      ts_tick_out,
  output logic                      transfer_stop_any_out,
  output logic                      skip_fetch_out,
  output logic                      skip_command_out,
  output logic                      skip_chan_seq_out,
  output logic [15:0]               controller_state_bits_out
);
  initial begin
    if (STOP_W < 1 || STOP_W > 32) $error("ccsb_state_bits: bad STOP_W");
  end

  ccsb_ts_if ts ();

  ccsb_time_state #(
    .DIV (TS_DIV)
  ) u_ts (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .init_in   (init_in),
    .ts        (ts)
  );

  // ==========================================================
  // sequencer flags
  // ==========================================================
  ccsb_seq_t  seq_r,   seq_nxt;
  logic       lock_r,  lock_nxt;
  logic [2:0] phase_r, phase_nxt;
  logic       quick_r, quick_nxt;
  logic       sync_r,  sync_nxt;
  logic       udv_r,   udv_nxt;
  logic       skip_r,  skip_nxt;
  logic       tick_w;
  logic       first_w;

  function automatic logic set_clr(input logic cur, input logic s,
                                   input logic c);
    // set beats clear when both arrive together
    set_clr = s ? 1'b1 : (c ? 1'b0 : cur);
  endfunction : set_clr

  always_comb begin
    tick_w    = ts.tick;
    first_w   = ts.first_ts;
    seq_nxt   = seq_r;
    lock_nxt  = lock_r;
    phase_nxt = phase_r;
    quick_nxt = quick_r;
    sync_nxt  = sync_r;
    udv_nxt   = udv_r;
    skip_nxt  = skip_r;
    case (seq_r)
      CCSB_SEQ_IDLE: begin
        if (chan_start_in) begin
          seq_nxt  = CCSB_SEQ_CHAN;
          lock_nxt = 1'b1;
        end
      end
      CCSB_SEQ_CHAN: begin
        if (chan_done_in && !chan_start_in) begin
          seq_nxt  = CCSB_SEQ_IDLE;
          lock_nxt = 1'b0;
        end
      end
      default: begin
        seq_nxt  = CCSB_SEQ_IDLE;
        lock_nxt = 1'b0;
      end
    endcase
    if (tick_w) begin
      if (phase_load_in) begin
        phase_nxt = phase_in;
      end
      quick_nxt = set_clr(quick_r, quick_busy_set_in,
                          quick_busy_clr_in);
      sync_nxt  = set_clr(sync_r, sync_set_in, sync_clr_in);
      udv_nxt   = set_clr(udv_r, udv_set_in, udv_clr_in);
      if (first_byte_in || zero_pointer_in) begin
        skip_nxt = 1'b1;
      end else if (phase_r == CCSB_PHASE_0 && seq_r == CCSB_SEQ_IDLE
                   && no_addr_out_in) begin
        skip_nxt = 1'b1;
      end else if (phase_r == CCSB_PHASE_2) begin
        skip_nxt = parity_good_in;
      end else if (phase_r == CCSB_PHASE_0 && first_w
                   && seq_r == CCSB_SEQ_CHAN) begin
        skip_nxt = status_pending_in;
      end else if (first_w && quick_busy_set_in) begin
        skip_nxt = 1'b1;
        sync_nxt = 1'b0;
      end else if (skip_clr_in) begin
        skip_nxt = 1'b0;
      end
    end
    if (init_in) begin
      seq_nxt   = CCSB_SEQ_IDLE;
      lock_nxt  = 1'b0;
      phase_nxt = CCSB_PHASE_RESET;
      quick_nxt = 1'b0;
      sync_nxt  = 1'b0;
      udv_nxt   = 1'b0;
      skip_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seq_r   <= CCSB_SEQ_IDLE;
      lock_r  <= 1'b0;
      phase_r <= CCSB_PHASE_RESET;
      quick_r <= 1'b0;
      sync_r  <= 1'b0;
      udv_r   <= 1'b0;
      skip_r  <= 1'b0;
    end else begin
      seq_r   <= seq_nxt;
      lock_r  <= lock_nxt;
      phase_r <= phase_nxt;
      quick_r <= quick_nxt;
      sync_r  <= sync_nxt;
      udv_r   <= udv_nxt;
      skip_r  <= skip_nxt;
    end
  end

  // ==========================================================
  // read view and decodes
  // ==========================================================
  logic stop_w;

  always_comb begin
    stop_w = (|stop_cond_in) &&
             (phase_r == CCSB_PHASE_5 || phase_r == CCSB_PHASE_6);
    host_wr_ok_out = host_wr_in &&
                     !(lock_r && 32'(host_wr_reg_in) < CCSB_LOCKED_REGS);
    controller_state_bits_out = 16'h0000;
    controller_state_bits_out[CCSB_LOCK_BIT]              = lock_r;
    controller_state_bits_out[CCSB_PHASE_HI:CCSB_PHASE_LO] = phase_r;
    controller_state_bits_out[CCSB_TS_BIT]                = first_w;
    controller_state_bits_out[CCSB_QUICK_BIT]             = quick_r;
    controller_state_bits_out[CCSB_SYNC_BIT]              = sync_r;
    controller_state_bits_out[CCSB_UDV_BIT]               = udv_r;
    controller_state_bits_out[CCSB_STOP_BIT]              = stop_w;
    controller_state_bits_out[CCSB_SKIP_BIT]              = skip_r;
    controller_state_bits_out[CCSB_LOW_W-1:0]             = low_bits_in;
    if (init_in) begin
      controller_state_bits_out[CCSB_LOW_W-1:0] =
        low_bits_in & (6'h01 << CCSB_ONLINE_BIT);
    end
  end

  assign host_write_lock_out   = lock_r;
  assign first_time_state_out  = first_w;
  assign ts_tick_out           = tick_w;
  assign transfer_stop_any_out = stop_w;
  assign skip_fetch_out        = skip_r && phase_r == CCSB_PHASE_0;
  assign skip_command_out      = skip_r && phase_r == CCSB_PHASE_3;
  assign skip_chan_seq_out     = skip_r && !sync_r && !first_w;
endmodule : ccsb_state_bits

// file: verilog/ccsb_time_state.sv
// time-state generator: alternates first and second time state
// assumes clk_in at 200 MHz; tick is a one-cycle enable
`timescale 1ns/1ps
module ccsb_time_state
  import ccsb_pkg::*;
#(
  parameter int unsigned DIV = CCSB_TS_DIV
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic init_in,
  ccsb_ts_if.gen    ts
);
  initial begin
    if (DIV < 2 || DIV > 65535) $error("ccsb_time_state: bad DIV");
  end

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        flag_r;
  logic        flag_nxt;
  logic        tick_w;

  always_comb begin
    tick_w   = (cnt_r == 16'(DIV - 1));
    cnt_nxt  = tick_w ? 16'h0000 : cnt_r + 16'h0001;
    flag_nxt = tick_w ? ~flag_r : flag_r;
    if (init_in) begin
      cnt_nxt  = 16'h0000;
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r  <= 16'h0000;
      flag_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign ts.tick     = tick_w & ~init_in;
  assign ts.first_ts = flag_r;
endmodule : ccsb_time_state

// file: verilog/ccsb_ts_if.sv
// time-state signals passed from the generator to the state bits
// assumes one clock domain
`timescale 1ns/1ps
interface ccsb_ts_if;
  logic tick;
  logic first_ts;
  modport gen (output tick, output first_ts);
  modport use_ts (input tick, input first_ts);
endinterface : ccsb_ts_if
